// ===== asra_map.vh
// constants of the async to sync rate adapter
// assumes: included by bare name from the rate adapter design file
`ifndef ASRA_MAP_VH
`define ASRA_MAP_VH

// ------------------------------------------------------------------
// character length selection {char_len_sel_hi, char_len_sel_lo}
// ------------------------------------------------------------------
// a switch that is ON reads as 1
`define ASRA_SEL_LEN_8 2'h2
`define ASRA_SEL_LEN_9 2'h3
`define ASRA_SEL_LEN_10 2'h0
`define ASRA_SEL_LEN_11 2'h1
`define ASRA_LEN_8 4'h8
`define ASRA_LEN_9 4'h9
`define ASRA_LEN_10 4'ha
`define ASRA_LEN_11 4'hb
`define ASRA_FRAME_W 11
`define ASRA_FRAME_MSB 10

// ------------------------------------------------------------------
// rate tolerance: full characters sent between two stop deletions
// ------------------------------------------------------------------
// 7 between gives one deletion in every 8 chars (+1 %), 3 one in every
// 4 (+2.3 %); one more would let a fast terminal overrun the slot
`define ASRA_DEL_GAP_NARROW 4'h7
`define ASRA_DEL_GAP_WIDE 4'h3

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define ASRA_RTS_HOLD_BITS 3'h4
`define ASRA_PER_W 16
`define ASRA_PER_MAX 16'hffff
`define ASRA_IDX_W 4
`define ASRA_MARK 1'b1
// synchroniser reset levels {rxd, rts, txd}: data at mark, request off
`define ASRA_PIN_IDLE 3'h5
`define ASRA_SPACE 1'b0

`endif

// ===== asra_edge_det.v
// two-flop synchroniser with edge pulses for a clock arriving on a pin
// assumes: pin is asynchronous to ref_clk and much slower than it
`timescale 1ns/1ps
module asra_edge_det
(
   input wire ref_clk,
   input wire sys_rst,
   input wire pin_in,
   output wire level,
   output wire rise,
   output wire fall
);

reg meta_reg;
reg sync_reg;
reg last_reg;

always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
   end
   else
   begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
   end
end

assign level = sync_reg;
assign rise = sync_reg & ~last_reg;
assign fall = ~sync_reg & last_reg;

endmodule

// ===== asra_rate_adapter.v
// async to sync rate adapter: terminal character stream to and from a
// synchronous data set bit stream
// assumes: data set supplies transmit and receive bit clocks, all pins
// are asynchronous to ref_clk, switches are static
`timescale 1ns/1ps
`include "asra_map.vh"
module asra_rate_adapter
(
   input wire ref_clk,
   input wire sys_rst,
   input wire char_len_sel_lo,
   input wire char_len_sel_hi,
   input wire wide_tolerance_sel,
   input wire unused_switch,
   input wire async_txd,
   input wire async_rts,
   input wire sync_txc,
   input wire sync_rxc,
   input wire sync_rxd,
   output reg sync_txd_reg,
   output reg sync_rts_reg,
   output reg async_rxd_reg
);

// ------------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------------
wire [2:0] pin_raw;
wire [2:0] pin_s;
// request resets inactive, else a reset alone would raise it
wire [2:0] pin_idle = `ASRA_PIN_IDLE;
reg [2:0] pin_meta_reg;
reg [2:0] pin_sync_reg;

assign pin_raw = {sync_rxd, async_rts, async_txd};

genvar gi;
generate
   for (gi = 0; gi < 3; gi = gi + 1)
   begin : g_pin
      always @(posedge ref_clk)
      begin
         if (sys_rst)
         begin
            pin_meta_reg[gi] <= pin_idle[gi];
            pin_sync_reg[gi] <= pin_idle[gi];
         end
         else
         begin
            pin_meta_reg[gi] <= pin_raw[gi];
            pin_sync_reg[gi] <= pin_meta_reg[gi];
         end
      end
   end
endgenerate

assign pin_s = pin_sync_reg;

wire txd_s = pin_s[0];
wire rts_s = pin_s[1];
wire rxd_s = pin_s[2];
wire txc_rise;
wire txc_fall;
wire rxc_rise;

asra_edge_det u_txc
(
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .pin_in(sync_txc),
   .level(),
   .rise(txc_rise),
   .fall(txc_fall)
);

asra_edge_det u_rxc
(
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .pin_in(sync_rxc),
   .level(),
   .rise(rxc_rise),
   .fall()
);

// ------------------------------------------------------------------
// configuration
// ------------------------------------------------------------------
reg [`ASRA_IDX_W-1:0] char_len;
wire [`ASRA_IDX_W-1:0] last_idx = char_len - 4'h1;
wire [`ASRA_IDX_W-1:0] stop_pre = char_len - 4'h2;
wire [3:0] del_gap;

always @*
begin
   case ({char_len_sel_hi, char_len_sel_lo})
      `ASRA_SEL_LEN_8: char_len = `ASRA_LEN_8;
      `ASRA_SEL_LEN_9: char_len = `ASRA_LEN_9;
      `ASRA_SEL_LEN_11: char_len = `ASRA_LEN_11;
      default: char_len = `ASRA_LEN_10;
   endcase
end

assign del_gap = wide_tolerance_sel ? `ASRA_DEL_GAP_WIDE :
   `ASRA_DEL_GAP_NARROW;

// ------------------------------------------------------------------
// bit period measured from the transmit clock
// ------------------------------------------------------------------
// async sampling follows the data set clock, no rate setting
// 16-bit count covers the slowest rate at 100 MHz
reg [`ASRA_PER_W-1:0] per_cnt_reg;
reg [`ASRA_PER_W-1:0] bit_per_reg;
reg per_ok_reg;

always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      per_cnt_reg <= {`ASRA_PER_W{1'b0}};
      bit_per_reg <= {`ASRA_PER_W{1'b0}};
      per_ok_reg <= 1'b0;
   end
   else if (txc_rise)
   begin
      per_cnt_reg <= {`ASRA_PER_W{1'b0}};
      bit_per_reg <= per_cnt_reg;
      per_ok_reg <= (per_cnt_reg != {`ASRA_PER_W{1'b0}});
   end
   else if (per_cnt_reg != `ASRA_PER_MAX)
   begin
      per_cnt_reg <= per_cnt_reg + 16'h1;
   end
end

// ------------------------------------------------------------------
// async character capture
// ------------------------------------------------------------------
localparam CAP_IDLE = 3'h1;
localparam CAP_START = 3'h2;
localparam CAP_BITS = 3'h4;

reg [2:0] cap_st_reg;
reg [`ASRA_PER_W-1:0] smp_cnt_reg;
reg [`ASRA_IDX_W-1:0] cap_idx_reg;
reg [`ASRA_FRAME_MSB:0] cap_frame_reg;
reg cap_done_reg;
wire smp_now = (smp_cnt_reg == {`ASRA_PER_W{1'b0}});

always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      cap_st_reg <= CAP_IDLE;
      smp_cnt_reg <= {`ASRA_PER_W{1'b0}};
      cap_idx_reg <= {`ASRA_IDX_W{1'b0}};
      cap_frame_reg <= {`ASRA_FRAME_W{`ASRA_MARK}};
      cap_done_reg <= 1'b0;
   end
   else
   begin
      cap_done_reg <= 1'b0;
      if (!smp_now)
      begin
         smp_cnt_reg <= smp_cnt_reg - 16'h1;
      end
      case (cap_st_reg)
         CAP_IDLE:
         begin
            if (per_ok_reg && txd_s == `ASRA_SPACE)
            begin
               smp_cnt_reg <= {1'b0, bit_per_reg[`ASRA_PER_W-1:1]};
               cap_st_reg <= CAP_START;
            end
         end
         CAP_START:
         begin
            if (smp_now)
            begin
               // a glitch shorter than half a bit is not a start
               if (txd_s == `ASRA_SPACE)
               begin
                  cap_frame_reg[0] <= `ASRA_SPACE;
                  cap_idx_reg <= 4'h1;
                  smp_cnt_reg <= bit_per_reg;
                  cap_st_reg <= CAP_BITS;
               end
               else
               begin
                  cap_st_reg <= CAP_IDLE;
               end
            end
         end
         CAP_BITS:
         begin
            if (smp_now)
            begin
               cap_frame_reg[cap_idx_reg] <= txd_s;
               smp_cnt_reg <= bit_per_reg;
               cap_idx_reg <= cap_idx_reg + 4'h1;
               if (cap_idx_reg == last_idx)
               begin
                  // back to idle at mid-stop, ready for the next start
                  cap_done_reg <= 1'b1;
                  cap_st_reg <= CAP_IDLE;
               end
            end
         end
         default:
         begin
            cap_st_reg <= CAP_IDLE;
         end
      endcase
   end
end

// ------------------------------------------------------------------
// sync transmit: one holding character and one frame in flight
// ------------------------------------------------------------------
reg [`ASRA_FRAME_MSB:0] hold_reg;
reg hold_full_reg;
reg [`ASRA_FRAME_MSB:0] tx_frame_reg;
reg [`ASRA_IDX_W-1:0] tx_idx_reg;
reg tx_busy_reg;
reg [3:0] since_del_reg;
wire tx_take;
wire del_ok = (since_del_reg >= del_gap);

// shorten stop when the terminal runs fast
assign tx_take = txc_fall && hold_full_reg &&
   ((!tx_busy_reg) || (tx_idx_reg == last_idx) ||
   (tx_idx_reg == stop_pre && del_ok));

// no block limit, the holding slot recycles forever
// overrun: a new char overwrites an unsent one
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      hold_reg <= {`ASRA_FRAME_W{`ASRA_MARK}};
      hold_full_reg <= 1'b0;
   end
   else if (cap_done_reg)
   begin
      hold_reg <= cap_frame_reg;
      hold_full_reg <= 1'b1;
   end
   else if (tx_take)
   begin
      hold_full_reg <= 1'b0;
   end
end

// data changes on txc falling edge
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      tx_frame_reg <= {`ASRA_FRAME_W{`ASRA_MARK}};
      tx_idx_reg <= {`ASRA_IDX_W{1'b0}};
      tx_busy_reg <= 1'b0;
      since_del_reg <= 4'h0;
      sync_txd_reg <= `ASRA_MARK;
   end
   else if (txc_fall)
   begin
      if (tx_take)
      begin
         tx_frame_reg <= hold_reg;
         tx_idx_reg <= {`ASRA_IDX_W{1'b0}};
         tx_busy_reg <= 1'b1;
         sync_txd_reg <= hold_reg[0];
         if (tx_busy_reg && tx_idx_reg == stop_pre)
         begin
            since_del_reg <= 4'h0;
         end
         else if (since_del_reg != 4'hf)
         begin
            since_del_reg <= since_del_reg + 4'h1;
         end
      end
      else if (tx_busy_reg && tx_idx_reg != last_idx)
      begin
         tx_idx_reg <= tx_idx_reg + 4'h1;
         sync_txd_reg <= tx_frame_reg[tx_idx_reg + 4'h1];
      end
      else
      begin
         // slow terminal: stop lengthened by idle mark
         tx_busy_reg <= 1'b0;
         sync_txd_reg <= `ASRA_MARK;
      end
   end
end

// ------------------------------------------------------------------
// request to send with flush delay
// ------------------------------------------------------------------
reg [2:0] rts_cnt_reg;

always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      sync_rts_reg <= 1'b0;
      rts_cnt_reg <= 3'h0;
   end
   else if (rts_s)
   begin
      sync_rts_reg <= 1'b1;
      rts_cnt_reg <= 3'h0;
   end
   else if (sync_rts_reg && txc_fall)
   begin
      rts_cnt_reg <= rts_cnt_reg + 3'h1;
      if (rts_cnt_reg == `ASRA_RTS_HOLD_BITS - 3'h1)
      begin
         sync_rts_reg <= 1'b0;
      end
   end
end

// ------------------------------------------------------------------
// sync receive toward the terminal
// ------------------------------------------------------------------
// receive clock times this direction alone
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      async_rxd_reg <= `ASRA_MARK;
   end
   else if (rxc_rise)
   begin
      async_rxd_reg <= rxd_s;
   end
end

endmodule

// ===== asra_rate_adapter_monitor.sv
// port checker for the async to sync rate adapter
// assumes: bound to asra_rate_adapter, data set clocks near 125 ns
`timescale 1ns/1ps
module asra_rate_adapter_monitor
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic char_len_sel_lo,
   input wire logic char_len_sel_hi,
   input wire logic wide_tolerance_sel,
   input wire logic unused_switch,
   input wire logic async_txd,
   input wire logic async_rts,
   input wire logic sync_txc,
   input wire logic sync_rxc,
   input wire logic sync_rxd,
   input wire logic sync_txd_reg,
   input wire logic sync_rts_reg,
   input wire logic async_rxd_reg
);
   // synchronisers hold stale values just after reset
   logic [3:0] age_reg;
   always_ff @(posedge ref_clk)
      age_reg <= sys_rst ? 4'h0 : (age_reg == 4'hf ? age_reg : age_reg + 4'h1);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_txd_edge;
      $changed(sync_txd_reg) |-> !$past(sync_txc, 2) && $past(sync_txc, 6);
   endproperty
   a_txd_edge: assert property (p_txd_edge)
      else $error("transmit data moved off a clock fall");
   property p_rx_edge;
      $changed(async_rxd_reg) && age_reg == 4'hf
         |-> $past(sync_rxc, 2) && !$past(sync_rxc, 6);
   endproperty
   a_rx_edge: assert property (p_rx_edge)
      else $error("terminal data moved off a clock rise");
   property p_rx_value;
      $rose(sync_rxc) && age_reg == 4'hf
         |-> ##5 async_rxd_reg == $past(sync_rxd, 5);
   endproperty
   a_rx_value: assert property (p_rx_value)
      else $error("terminal data differs from line data");
   property p_rts_rise;
      $rose(async_rts) |-> ##[2:5] sync_rts_reg;
   endproperty
   a_rts_rise: assert property (p_rts_rise)
      else $error("request not passed on");
   property p_rts_cause;
      $rose(sync_rts_reg) |-> $past(async_rts, 2);
   endproperty
   a_rts_cause: assert property (p_rts_cause)
      else $error("request raised with no terminal request");
   property p_rts_hold;
      $fell(async_rts) && sync_rts_reg |-> ##30 sync_rts_reg;
   endproperty
   a_rts_hold: assert property (p_rts_hold)
      else $error("request dropped too early");
   property p_rts_drop;
      $fell(async_rts) |-> ##[36:56] !sync_rts_reg;
   endproperty
   a_rts_drop: assert property (p_rts_drop)
      else $error("request held too long");
   property p_rts_edge;
      $fell(sync_rts_reg) |-> !$past(async_rts, 2)
         && !$past(sync_txc, 2) && $past(sync_txc, 6);
   endproperty
   a_rts_edge: assert property (p_rts_edge)
      else $error("request dropped off a clock fall");
   property p_reset;
      disable iff (1'b0)
      sys_rst |=> sync_txd_reg && !sync_rts_reg && async_rxd_reg;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not idle in reset");
endmodule
bind asra_rate_adapter asra_rate_adapter_monitor asra_rate_adapter_monitor_inst
(
   .ref_clk(ref_clk), .sys_rst(sys_rst), .char_len_sel_lo(char_len_sel_lo),
   .char_len_sel_hi(char_len_sel_hi), .unused_switch(unused_switch),
   .wide_tolerance_sel(wide_tolerance_sel), .async_txd(async_txd),
   .async_rts(async_rts), .sync_txc(sync_txc), .sync_rxc(sync_rxc),
   .sync_rxd(sync_rxd), .sync_txd_reg(sync_txd_reg),
   .sync_rts_reg(sync_rts_reg), .async_rxd_reg(async_rxd_reg)
);

// ===== asra_dataset_model.sv
// synchronous data set: free running bit clocks, random receive data
// assumes: bench seeds the random generator at time zero
`timescale 1ns/1ps
module asra_dataset_model
(
   output logic sync_txc,
   output logic sync_rxc,
   output logic sync_rxd
);
   initial
   begin
      sync_txc = 1'b1;
      // small offset keeps clock edges off the ref_clk edges
      #2;
      forever #62.5 sync_txc = ~sync_txc;
   end
   initial
   begin
      sync_rxc = 1'b1;
      sync_rxd = 1'b1;
      #17;
      forever
      begin
         #62.5 sync_rxc = 1'b0;
         sync_rxd = 1'($urandom);
         #62.5 sync_rxc = 1'b1;
      end
   end
endmodule

// ===== asra_rate_adapter_test.sv
// self-checking bench for the async to sync rate adapter
// assumes: data set model makes clocks, bench acts as terminal
`timescale 1ns/1ps
module asra_rate_adapter_test;
   logic ref_clk, sys_rst, lo, hi, wide, spare, txd, rts;
   wire txc, rxc, rxd, stxd, srts, arxd;
   logic [10:0] exp_q[$];
   logic [10:0] f, mask;
   int n_errors = 0;
   int total_checks = 0;
   int frame_len = 10;
   int lens[4] = '{10, 11, 8, 9};
   real bit_ns, due;
   asra_dataset_model asra_dataset_model_inst
      (.sync_txc(txc), .sync_rxc(rxc), .sync_rxd(rxd));
   asra_rate_adapter asra_rate_adapter_inst
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .char_len_sel_lo(lo),
      .char_len_sel_hi(hi), .wide_tolerance_sel(wide),
      .unused_switch(spare), .async_txd(txd), .async_rts(rts),
      .sync_txc(txc), .sync_rxc(rxc), .sync_rxd(rxd),
      .sync_txd_reg(stxd), .sync_rts_reg(srts), .async_rxd_reg(arxd)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic finish_test;
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic compare(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic compare_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // fractional bit time, edges land just after a clock edge
   task automatic send_char(input logic [10:0] c);
      for (int i = 0; i < frame_len; i++)
      begin
         txd = c[i];
         due = due + bit_ns;
         while ($realtime < due)
         begin
            @(posedge ref_clk);
            #1;
         end
      end
   endtask
   // --------------------------------------------------------------
   // line watcher: stop slot may carry the next start
   // --------------------------------------------------------------
   initial
   begin : watch
      logic [10:0] got;
      forever
      begin
         @(posedge txc);
         if (stxd === 1'b0 && sys_rst === 1'b0)
         begin
            got = 11'h0;
            for (int i = 1; i < frame_len - 1; i++)
            begin
               @(posedge txc);
               got[i] = stxd;
            end
            compare(got, exp_q.size() > 0 ? exp_q.pop_front() : 11'h7ff);
         end
      end
   end
   initial
   begin
      #400000;
      n_errors++;
      finish_test();
   end
   // --------------------------------------------------------------
   // every length and tolerance, fast terminal; last run slow
   // --------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h9a5a));
      {sys_rst, lo, hi, wide, spare, txd, rts} = 7'b1000010;
      for (int cfg = 0; cfg < 9; cfg++)
      begin
         @(posedge ref_clk);
         #1;
         {wide, hi, lo} = 3'(cfg);
         frame_len = lens[{hi, lo}];
         mask = (11'h1 << (frame_len - 1)) - 11'h1;
         // fast inside each window, last run slow
         bit_ns = cfg == 8 ? 128.0 : (wide ? 122.4 : 123.9);
         spare = 1'($urandom);
         sys_rst = 1'b1;
         repeat (3) @(posedge ref_clk);
         #1 sys_rst = 1'b0;
         repeat (80) @(posedge ref_clk);
         #1 rts = 1'b1;
         due = $realtime;
         for (int k = 0; k < 16; k++)
         begin
            f = 11'($urandom);
            f[0] = 1'b0;
            f[frame_len - 1] = 1'b1;
            exp_q.push_back(f & mask);
            send_char(f);
         end
         for (int w = 0; w < 600 && exp_q.size() > 0; w++)
            @(posedge ref_clk);
         compare(11'(exp_q.size()), 11'h0);
         exp_q.delete();
         repeat (30) @(posedge ref_clk);
         // drop just after a clock fall, so that fall is not counted
         @(negedge txc);
         @(posedge ref_clk);
         #1 rts = 1'b0;
         repeat (3) @(negedge txc);
         repeat (6) @(posedge ref_clk);
         compare_bit(srts, 1'b1);
         repeat (2) @(negedge txc);
         repeat (6) @(posedge ref_clk);
         compare_bit(srts, 1'b0);
      end
      finish_test();
   end
endmodule
